// >>> rtl/ind_conv_pkg.sv
// Shared constants, register map and types of the converter mode control.
// Assumes a 100 MHz core clock and byte registers on a 7-bit address.
package ind_conv_pkg;
  localparam int CLK_MHZ          = 100;
  localparam int START_TIME_US    = 800;
  localparam int START_CYCLES_DEF = START_TIME_US * CLK_MHZ;
  localparam int WD_TIME_US       = 20;
  localparam int WD_CYCLES        = WD_TIME_US * CLK_MHZ;
  localparam int SHUT_EXIT_EDGES  = 4;
  localparam int HIRES_BASE       = 55;
  localparam int HIRES_STEP_LOG2  = 4;
  // Register addresses
  localparam logic [6:0] ADDR_RANGE  = 7'h01;
  localparam logic [6:0] ADDR_TC1    = 7'h02;
  localparam logic [6:0] ADDR_TC2    = 7'h03;
  localparam logic [6:0] ADDR_RESP   = 7'h04;
  localparam logic [6:0] ADDR_ALT    = 7'h05;
  localparam logic [6:0] ADDR_REPORT = 7'h0a;
  localparam logic [6:0] ADDR_POWER  = 7'h0b;
  localparam logic [6:0] ADDR_AMP    = 7'h0c;
  localparam logic [6:0] ADDR_STATUS = 7'h20;
  localparam logic [6:0] ADDR_RP_LO  = 7'h21;
  localparam logic [6:0] ADDR_RP_HI  = 7'h22;
  localparam logic [6:0] ADDR_L_LO   = 7'h23;
  localparam logic [6:0] ADDR_L_HI   = 7'h24;
  localparam logic [6:0] ADDR_CNT_LO = 7'h30;
  localparam logic [6:0] ADDR_CNT_HI = 7'h31;
  localparam logic [6:0] ADDR_HR_0   = 7'h38;
  localparam logic [6:0] ADDR_HR_1   = 7'h39;
  localparam logic [6:0] ADDR_HR_2   = 7'h3a;
  localparam logic [6:0] ADDR_HR_ST  = 7'h3b;
  // Reset values
  localparam logic [7:0] RANGE_RESET  = 8'h07;
  localparam logic [7:0] TC1_RESET    = 8'h90;
  localparam logic [7:0] TC2_RESET    = 8'ha0;
  localparam logic [7:0] RESP_RESET   = 8'h03;
  localparam logic [7:0] POWER_RESET  = 8'h01;
  localparam logic [7:0] CNT_LO_RESET = 8'h00;
  localparam logic [7:0] CNT_HI_RESET = 8'h01;
  // Field positions and codes
  localparam int RANGE_MIN_LSB = 0;
  localparam int RANGE_MAX_LSB = 4;
  localparam int ALT_LONLY_BIT = 0;
  localparam int ALT_SHUT_BIT  = 1;
  localparam int AMP_OK_BIT    = 0;
  localparam int STAT_OSC_BIT  = 7;
  localparam int STAT_DRDY_BIT = 6;
  localparam int STAT_POR_BIT  = 0;
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_SHUT   = 2'h2;
  localparam logic [2:0] RESP_MIN    = 3'h2;
  localparam logic [12:0] RESP_BASE  = 13'h0003;
  localparam logic [2:0] REPORT_DRDY = 3'h4;
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SHUT   = 3'b100
  } power_t;
endpackage

// >>> rtl/sync2.sv
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that stays long enough to be seen.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;
  sync_t st;
  sync_t next_st;

  // The first stage feeds only the second
  always_comb begin
    next_st.first  = async_in;
    next_st.second = st.first;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= {RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.second;
endmodule
`default_nettype wire

// >>> rtl/hires_engine.sv
// High-resolution inductance engine, clocked by the reference clock.
// Assumes run and count are steady for several reference cycles.
`timescale 1ns/100ps
`default_nettype none
module hires_engine
  import ind_conv_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [15:0] count_in,
  input  wire logic        sensor_in,
  output logic      [23:0] result_out,
  output logic             done_toggle_out,
  output logic             alive_out
);
  typedef struct packed {
    logic [20:0] cyc;
    logic [20:0] limit;
    logic [23:0] edges;
    logic [23:0] result;
    logic        done;
    logic        alive;
    logic        sensor_d;
    logic        running;
  } hires_t;
  hires_t     st;
  hires_t     next_st;
  logic       rst_s;
  logic       run_s;
  logic       sensor_s;
  logic       sens_rise;
  logic [20:0] limit_now;

  sync2 #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync (
    .clock_in (clock_in),
    .rst_in   (1'b0),
    .async_in ({rst_in, run_in, sensor_in}),
    .sync_out ({rst_s, run_s, sensor_s})
  );

  // Interval is base plus sixteen cycles per count step
  always_comb begin
    limit_now = 21'(HIRES_BASE) + {1'b0, count_in, 4'h0};
    sens_rise = sensor_s & ~st.sensor_d;
    next_st = st;
    next_st.alive = ~st.alive;
    next_st.sensor_d = sensor_s;
    if (!run_s) begin
      next_st.running = 1'b0;
      next_st.cyc = '0;
      next_st.edges = '0;
    end else if (!st.running || st.cyc == st.limit - 21'd1) begin
      if (st.running) begin
        next_st.result = st.edges + {23'h0, sens_rise};
        next_st.done = ~st.done;
      end
      next_st.running = 1'b1;
      next_st.limit = limit_now;
      next_st.cyc = '0;
      next_st.edges = '0;
    end else begin
      next_st.cyc = st.cyc + 21'd1;
      next_st.edges = st.edges + {23'h0, sens_rise};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_s) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result_out      = st.result;
  assign done_toggle_out = st.done;
  assign alive_out       = st.alive;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_s);

  a_hires_period: assert property (
    (run_s && st.running && st.cyc == st.limit - 21'd1) |=> $changed(st.done) && st.cyc == 21'd0)
    else $error("hires result not delivered at interval end");
  a_hires_idle: assert property (
    !run_s ##1 !run_s |-> $stable(st.done) && $stable(st.result))
    else $error("hires engine converted while stopped");
endmodule
`default_nettype wire

// >>> rtl/inductive_converter_mode_control.sv
// Mode and power-state control of a two-engine inductance converter.
// Assumes serial pins, sensor and reference clock are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module inductive_converter_mode_control
  import ind_conv_pkg::*;
#(
  parameter int START_CYCLES = START_CYCLES_DEF
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        ref_clk_in,
  input  wire logic        sensor_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  input  wire logic [15:0] rp_code_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  output logic      [2:0]  drive_min_out,
  output logic      [2:0]  drive_max_out,
  output logic      [7:0]  time_const1_out,
  output logic      [7:0]  time_const2_out,
  output logic             sensor_drive_en_out,
  output logic      [2:0]  power_state_out
);
  if (START_CYCLES < 2 || START_CYCLES > 1048575) begin : g_bad_start
    $error("START_CYCLES must fit 20 bits");
  end

  typedef struct packed {
    power_t      pwr;
    logic [7:0]  range_set;
    logic [7:0]  tc1;
    logic [7:0]  tc2;
    logic [7:0]  resp;
    logic [7:0]  alt;
    logic [7:0]  report;
    logic [7:0]  pwr_cfg;
    logic [7:0]  amp;
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
    logic        por;
    logic [19:0] por_cnt;
    logic        drdy_n;
    logic        no_osc;
    logic        hr_ready;
    logic [15:0] wd_cnt;
    logic [12:0] edge_cnt;
    logic [15:0] len_cnt;
    logic [15:0] rp_data;
    logic [15:0] l_data;
    logic [23:0] hr_data;
    logic [2:0]  exit_edges;
    logic        run;
    logic        sclk_d;
    logic        sensor_d;
    logic        alive_d;
    logic        done_d;
    logic        hdr_done;
    logic        rw;
    logic [2:0]  bit_cnt;
    logic [6:0]  addr;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic        sdo;
    logic        sdo_oe;
  } core_t;

  core_t       st;
  core_t       n;
  logic [5:0]  pins_s;
  logic        sclk_s;
  logic        cs_n_s;
  logic        mosi_s;
  logic        sensor_s;
  logic        alive_s;
  logic        done_s;
  logic [23:0] hr_result;
  logic        hr_toggle;
  logic        hr_alive;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sens_rise;
  logic        hr_done;
  logic        byte_done;
  logic        wr_en;
  logic        rd_load;
  logic        conv_done;
  logic        go_shut;
  logic [7:0]  rx_byte;

  // Pins and the reference-domain signals into the core clock
  sync2 #(.WIDTH(6), .RESET_VAL(6'h02)) u_pins (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in ({hr_toggle, hr_alive, sensor_in, mosi_in, cs_n_in, sclk_in}),
    .sync_out (pins_s)
  );
  assign {done_s, alive_s, sensor_s, mosi_s, cs_n_s, sclk_s} = pins_s;

  // Hires engine runs on the reference clock beside the combined one
  hires_engine u_hires (
    .clock_in        (ref_clk_in),
    .rst_in          (rst_in),
    .run_in          (st.run),
    .count_in        ({st.cnt_hi, st.cnt_lo}),
    .sensor_in       (sensor_in),
    .result_out      (hr_result),
    .done_toggle_out (hr_toggle),
    .alive_out       (hr_alive)
  );

  // Default register image; the serial frame in flight survives
  function automatic core_t fresh(input core_t cur, input power_t p, input logic por);
    core_t s;
    s = '0;
    s.pwr = p;
    s.range_set = RANGE_RESET;
    s.tc1 = TC1_RESET;
    s.tc2 = TC2_RESET;
    s.resp = RESP_RESET;
    s.pwr_cfg = (p == ST_SHUT) ? {6'h0, MODE_SHUT} : POWER_RESET;
    s.cnt_lo = CNT_LO_RESET;
    s.cnt_hi = CNT_HI_RESET;
    s.drdy_n = 1'b1;
    s.por = por;
    s.sclk_d = cur.sclk_d;
    s.sensor_d = cur.sensor_d;
    s.alive_d = cur.alive_d;
    s.done_d = cur.done_d;
    s.hdr_done = cur.hdr_done;
    s.rw = cur.rw;
    s.bit_cnt = cur.bit_cnt;
    s.addr = cur.addr;
    s.rx = cur.rx;
    s.tx = cur.tx;
    s.sdo = cur.sdo;
    s.sdo_oe = cur.sdo_oe;
    return s;
  endfunction

  // Inductance-only needs both select bits
  function automatic logic l_only(input core_t s);
    return s.alt[ALT_LONLY_BIT] & s.amp[AMP_OK_BIT];
  endfunction

  // Sensor periods per combined conversion: 192 up to 6144
  function automatic logic [12:0] interval(input logic [7:0] r);
    logic [2:0] k;
    k = (r[2:0] < RESP_MIN) ? RESP_MIN : r[2:0];
    return RESP_BASE << (4'(k) + 4'd4);
  endfunction

  // Read-back of the register map; resistance reads zero when invalid
  function automatic logic [7:0] read_reg(input core_t s, input logic [6:0] a);
    logic [15:0] rp;
    rp = l_only(s) ? 16'h0000 : s.rp_data;
    case (a)
      ADDR_RANGE:  return s.range_set;
      ADDR_TC1:    return s.tc1;
      ADDR_TC2:    return s.tc2;
      ADDR_RESP:   return s.resp;
      ADDR_ALT:    return s.alt;
      ADDR_REPORT: return s.report;
      ADDR_POWER:  return s.pwr_cfg;
      ADDR_AMP:    return s.amp;
      ADDR_STATUS: return {s.no_osc, s.drdy_n, 5'h00, s.por};
      ADDR_RP_LO:  return rp[7:0];
      ADDR_RP_HI:  return rp[15:8];
      ADDR_L_LO:   return s.l_data[7:0];
      ADDR_L_HI:   return s.l_data[15:8];
      ADDR_CNT_LO: return s.cnt_lo;
      ADDR_CNT_HI: return s.cnt_hi;
      ADDR_HR_0:   return s.hr_data[7:0];
      ADDR_HR_1:   return s.hr_data[15:8];
      ADDR_HR_2:   return s.hr_data[23:16];
      ADDR_HR_ST:  return {7'h00, s.hr_ready};
      default:     return 8'h00;
    endcase
  endfunction

  // Next state of the whole block
  always_comb begin
    n = st;
    n.sclk_d = sclk_s;
    n.sensor_d = sensor_s;
    n.alive_d = alive_s;
    n.done_d = done_s;
    sclk_rise = sclk_s & ~st.sclk_d;
    sclk_fall = ~sclk_s & st.sclk_d;
    sens_rise = sensor_s & ~st.sensor_d;
    hr_done = done_s ^ st.done_d;
    rx_byte = {st.rx[6:0], mosi_s};
    byte_done = ~cs_n_s & sclk_rise & (st.bit_cnt == 3'd7);
    wr_en = byte_done & st.hdr_done & ~st.rw;
    rd_load = ~cs_n_s & sclk_fall & st.hdr_done & st.rw & (st.bit_cnt == 3'd0);
    conv_done = 1'b0;
    go_shut = 1'b0;

    // Serial port works in every power state
    if (cs_n_s) begin
      n.bit_cnt = 3'd0;
      n.hdr_done = 1'b0;
      n.sdo_oe = (st.report[2:0] == REPORT_DRDY);
      n.sdo = st.drdy_n;
    end else begin
      if (sclk_rise) begin
        n.rx = rx_byte;
        n.bit_cnt = st.bit_cnt + 3'd1;
        if (byte_done && !st.hdr_done) begin
          n.hdr_done = 1'b1;
          n.rw = rx_byte[7];
          n.addr = rx_byte[6:0];
        end else if (byte_done) begin
          n.addr = st.addr + 7'd1;
        end
      end
      if (rd_load) begin
        n.tx = read_reg(st, st.addr);
        n.sdo = n.tx[7];
      end else if (sclk_fall && st.hdr_done && st.rw) begin
        n.tx = {st.tx[6:0], 1'b0};
        n.sdo = st.tx[6];
      end
      n.sdo_oe = st.hdr_done & st.rw;
    end

    // Reads of the top data bytes clear the ready flags
    if (rd_load && st.addr == ADDR_L_HI) n.drdy_n = 1'b1;
    if (rd_load && st.addr == ADDR_HR_2) n.hr_ready = 1'b0;

    // Power-on flag holds for the start-up time
    if (st.por) begin
      n.por_cnt = st.por_cnt + 20'd1;
      if (st.por_cnt == 20'(START_CYCLES - 1)) n.por = 1'b0;
    end

    // Combined engine: interval set by sensor periods and response time
    if (st.pwr == ST_ACTIVE) begin
      n.len_cnt = (st.len_cnt == 16'hffff) ? st.len_cnt : st.len_cnt + 16'd1;
      n.wd_cnt = st.wd_cnt + 16'd1;
      if (st.wd_cnt == 16'(WD_CYCLES - 1)) begin
        n.no_osc = 1'b1;
        n.wd_cnt = st.wd_cnt;
      end
      if (sens_rise) begin
        n.wd_cnt = 16'd0;
        n.no_osc = 1'b0;
        n.edge_cnt = st.edge_cnt + 13'd1;
        if (st.edge_cnt == interval(st.resp) - 13'd1) conv_done = 1'b1;
      end
      if (conv_done) begin
        n.edge_cnt = 13'd0;
        n.len_cnt = 16'd0;
        n.l_data = st.len_cnt;
        if (!l_only(st)) n.rp_data = rp_code_in;
        n.drdy_n = 1'b0;
      end
      if (hr_done) begin
        n.hr_data = hr_result;
        n.hr_ready = 1'b1;
      end
    end else begin
      n.edge_cnt = 13'd0;
      n.len_cnt = 16'd0;
      n.wd_cnt = 16'd0;
    end

    // Register writes; reporting ones apply at once in any state
    if (wr_en) begin
      case (st.addr)
        ADDR_RANGE:  n.range_set = rx_byte;
        ADDR_TC1:    n.tc1 = rx_byte;
        ADDR_TC2:    n.tc2 = rx_byte;
        ADDR_RESP:   n.resp = rx_byte;
        ADDR_ALT:    n.alt = rx_byte;
        ADDR_REPORT: n.report = rx_byte;
        ADDR_AMP:    n.amp = rx_byte;
        ADDR_CNT_LO: n.cnt_lo = rx_byte;
        ADDR_CNT_HI: n.cnt_hi = rx_byte;
        ADDR_POWER: begin
          case (rx_byte[1:0])
            MODE_ACTIVE: begin
              n.pwr_cfg = rx_byte;
              n.pwr = ST_ACTIVE;
            end
            MODE_SLEEP: begin
              n.pwr_cfg = rx_byte;
              n.pwr = ST_SLEEP;
            end
            MODE_SHUT: go_shut = st.alt[ALT_SHUT_BIT];
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // Shutdown: defaults, cleared status, wait for the clock to return
    if (go_shut) begin
      n = fresh(n, ST_SHUT, 1'b0);
    end else if (st.pwr == ST_SHUT && (alive_s ^ st.alive_d)) begin
      n.exit_edges = st.exit_edges + 3'd1;
      if (st.exit_edges == 3'(SHUT_EXIT_EDGES - 1)) begin
        n = fresh(n, ST_SLEEP, 1'b1);
      end
    end
    n.run = (n.pwr == ST_ACTIVE);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= fresh(core_t'(0), ST_SLEEP, 1'b1);
    end else begin
      st <= n;
    end
  end

  // Range fields steer the front-end drive currents
  assign drive_min_out       = st.range_set[RANGE_MIN_LSB +: 3];
  assign drive_max_out       = st.range_set[RANGE_MAX_LSB +: 3];
  assign time_const1_out     = st.tc1;
  assign time_const2_out     = st.tc2;
  assign sensor_drive_en_out = st.run;
  assign power_state_out     = st.pwr;
  assign sdo_out             = st.sdo;
  assign sdo_oe_out          = st.sdo_oe;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_reserved_mode_kept: assert property (
    wr_en && st.addr == ADDR_POWER && rx_byte[1:0] == 2'h3
    |=> $stable(st.pwr) && $stable(st.pwr_cfg))
    else $error("reserved power code changed the state");
  a_sleep_entry: assert property (
    wr_en && st.addr == ADDR_POWER && rx_byte[1:0] == MODE_SLEEP
    |=> st.pwr == ST_SLEEP && st.range_set == $past(st.range_set))
    else $error("sleep write did not keep registers in sleep");
  a_active_entry: assert property (
    wr_en && st.addr == ADDR_POWER && rx_byte[1:0] == MODE_ACTIVE
    |=> st.pwr == ST_ACTIVE ##1 sensor_drive_en_out)
    else $error("active write did not start conversions");
  a_shut_entry: assert property (
    wr_en && st.addr == ADDR_POWER && rx_byte[1:0] == MODE_SHUT && st.alt[ALT_SHUT_BIT]
    |=> st.pwr == ST_SHUT && st.range_set == RANGE_RESET && st.alt == 8'h00)
    else $error("shutdown write not applied with defaults");
  a_shut_status: assert property (
    st.pwr == ST_SHUT |-> st.drdy_n && !st.no_osc && !st.hr_ready && !st.por)
    else $error("status not cleared in shutdown");
  a_idle_no_conv: assert property (
    st.pwr != ST_ACTIVE ##1 st.pwr == $past(st.pwr)
    |-> $stable(st.l_data) && $stable(st.rp_data) && $stable(st.hr_data))
    else $error("conversion result changed while idle");
  a_shut_exit: assert property (
    st.pwr == ST_SHUT ##1 st.pwr != ST_SHUT
    |-> st.pwr == ST_SLEEP && st.por && st.tc1 == TC1_RESET)
    else $error("shutdown exit did not land in sleep with defaults");
  a_lonly_rp_zero: assert property (
    rd_load && l_only(st) && (st.addr == ADDR_RP_LO || st.addr == ADDR_RP_HI)
    |=> st.tx == 8'h00)
    else $error("resistance read not zero in inductance-only");
  a_drdy_set_wins: assert property (
    conv_done && rd_load && st.addr == ADDR_L_HI |=> !st.drdy_n)
    else $error("new result lost against a flag clear");
  a_range_drive: assert property (
    wr_en && st.addr == ADDR_RANGE && !go_shut |=> drive_max_out == $past(rx_byte[6:4]))
    else $error("drive range not taken from range register");
endmodule
`default_nettype wire

// >>> sim/spi_host.sv
// Host model that drives the four-wire serial port in mode 0.
// Assumes the core clock paces its bit timing.
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  input  wire logic clock_in,
  input  wire logic sdo_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  // Wait whole clocks, then step off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // One 16-bit frame; sclk stays under 8 MHz, read bits taken on sclk rise
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {rw, addr, wdata};
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = bits[i];
      wait_clk(7);
      sclk_out = 1'b1;
      if (i < 8) rdata[i] = sdo_in;
      wait_clk(7);
      sclk_out = 1'b0;
    end
    wait_clk(4);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line shows no stale value
    wait_clk(12);
  endtask

  // Idle levels
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
endmodule
`default_nettype wire

// >>> sim/inductive_converter_mode_control_tb.sv
// Self-checking bench for the converter mode control.
// Assumes the host model paces every serial frame.
`timescale 1ns/100ps
`default_nettype none
module inductive_converter_mode_control_tb;
  import ind_conv_pkg::*;
  logic       clock_in   = 1'b0;
  logic       rst_in     = 1'b1;
  logic       ref_clk_in = 1'b0;
  logic       ref_run    = 1'b1;
  logic       sensor_in  = 1'b0;
  logic [15:0] rp_code   = 16'h1234;
  logic [7:0] rdata;
  int         errors      = 0;
  int         check_count = 0;
  wire        sclk, cs_n, mosi, sdo, sdo_oe, sdo_line, drive_en;
  wire  [2:0] drive_min, drive_max, power_state;
  wire  [7:0] tc1, tc2;

  // Core clock, reference clock that may be held low, sensor wave
  always #5 clock_in = ~clock_in;
  always begin
    #16;
    ref_clk_in = ref_run ? ~ref_clk_in : 1'b0;
  end
  always #50 sensor_in = ~sensor_in;
  assign sdo_line = sdo_oe ? sdo : ~sdo; // Released line shows no stale value

  inductive_converter_mode_control #(.START_CYCLES(20)) DUT (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .ref_clk_in         (ref_clk_in),
    .sensor_in          (sensor_in),
    .sclk_in            (sclk),
    .cs_n_in            (cs_n),
    .mosi_in            (mosi),
    .rp_code_in         (rp_code),
    .sdo_out            (sdo),
    .sdo_oe_out         (sdo_oe),
    .drive_min_out      (drive_min),
    .drive_max_out      (drive_max),
    .time_const1_out    (tc1),
    .time_const2_out    (tc2),
    .sensor_drive_en_out(drive_en),
    .power_state_out    (power_state)
  );
  spi_host host (
    .clock_in(clock_in),
    .sdo_in  (sdo_line),
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .mosi_out(mosi)
  );

  // Compare, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rdata);
  endtask
  task automatic rd(input logic [6:0] a);
    host.xfer(1'b1, a, 8'h00, rdata);
  endtask
  task automatic poll(input logic [6:0] a, input int bit_no, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      rd(a);
      if (rdata[bit_no] === v) break;
    end
  endtask

  // Reset defaults, then wait for the power-on flag before configuring
  task automatic test_defaults();
    check({drive_en, power_state, drive_max, drive_min}, 10'h047);
    check({tc1, tc2}, {TC1_RESET, TC2_RESET});
    poll(ADDR_STATUS, STAT_POR_BIT, 1'b0, 10);
    check(rdata[STAT_POR_BIT], 1'b0);
    rd(ADDR_POWER);
    check(rdata, POWER_RESET);
  endtask

  // Configuration while asleep, unmapped read
  task automatic test_sleep_config();
    wr(ADDR_RANGE, 8'h35);
    wr(ADDR_TC1, 8'h55);
    wr(ADDR_TC2, 8'h66);
    rd(ADDR_RANGE);
    check(rdata, 8'h35);
    check({drive_max, drive_min, tc1, tc2}, 22'h1d5566);
    rd(7'h10);
    check(rdata, 8'h00);
  endtask

  // Full result first, then L-only conversions, reserved code, reporting write
  task automatic test_active();
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_AMP, 8'h01);
    wr(ADDR_POWER, 8'h00);
    check({power_state, drive_en}, 4'b0101);
    poll(ADDR_STATUS, STAT_DRDY_BIT, 1'b0, 40);
    rd(ADDR_RP_LO);
    check(rdata, rp_code[7:0]);
    rd(ADDR_RP_HI);
    check(rdata, rp_code[15:8]);
    rd(ADDR_L_HI);
    wr(ADDR_POWER, 8'h01);
    wr(ADDR_ALT, 8'h01);
    wr(ADDR_POWER, 8'h00);
    wr(ADDR_POWER, 8'h03);
    check(power_state, 3'b010);
    wr(ADDR_REPORT, 8'h04);
    check({power_state, sdo_oe}, 4'b0101);
    poll(ADDR_STATUS, STAT_DRDY_BIT, 1'b0, 40);
    check(rdata[STAT_DRDY_BIT], 1'b0);
    rd(ADDR_HR_ST);
    check(rdata[0], 1'b1);
    rd(ADDR_RP_LO);
    check(rdata, 8'h00);
    rd(ADDR_RP_HI);
    check(rdata, 8'h00);
  endtask

  // Back to sleep: settings kept, both engines stopped
  task automatic test_sleep();
    wr(ADDR_POWER, 8'h01);
    check({power_state, drive_en}, 4'b0010);
    rd(ADDR_HR_2);
    host.wait_clk(300);
    rd(ADDR_HR_ST);
    check(rdata[0], 1'b0);
    rd(ADDR_RANGE);
    check(rdata, 8'h35);
  endtask

  // Shutdown from active, defaults restored, clock restart lands in sleep
  task automatic test_shutdown();
    wr(ADDR_ALT, 8'h02);
    wr(ADDR_POWER, 8'h00);
    ref_run = 1'b0;
    host.wait_clk(20);
    wr(ADDR_POWER, 8'h02);
    check({power_state, drive_en}, 4'b1000);
    check({drive_min, tc1, sdo_oe}, {3'h7, TC1_RESET, 1'b0});
    ref_run = 1'b1;
    for (int i = 0; i < 2000 && power_state !== 3'b001; i++) host.wait_clk(1);
    check(power_state, 3'b001);
    host.wait_clk(40);
    rd(ADDR_ALT);
    check(rdata, 8'h00);
    rd(ADDR_RANGE);
    check(rdata, RANGE_RESET);
  endtask

  // Main sequence
  initial begin
    host.wait_clk(12);
    rst_in = 1'b0;
    host.wait_clk(3);
    test_defaults();
    test_sleep_config();
    test_active();
    test_sleep();
    test_shutdown();
    complete_run();
  end

  // Watchdog against a hung frame or state change
  initial begin
    #900000;
    errors++;
    complete_run();
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
